//--- src/keypad_nav_map.svh
// Behaviour
// - Display and mode commands only, no configuration writes
// - Left digits show bank letter and index
// - Four lamps: fault, calibration, path, power
// - User bank 0..E with its detail classes
// - Service bank 0..E with its detail classes
// - Auxiliary bank 0..9 with its detail classes
// - Zero key alone requests zero calibration
// - Normal key alone commands normal mode
// - Path key toggles path; lamp lit for A
// - Span-low key alone requests span-low calibration
// - Span key with zero requests calibration cycle
// - Display+left held one second advances bank, repeats
// - Ten idle minutes return display to user bank
// - Display+increment raises index, auto-repeats
// - Display+step-down lowers index, auto-repeats
`ifndef KEYPAD_NAV_MAP_SVH
`define KEYPAD_NAV_MAP_SVH

// Key bit positions on the keypad bus
`define KEY_DISPLAY     0
`define KEY_LEFT        1
`define KEY_INC         2
`define KEY_STEP_DOWN   3
`define KEY_ZERO        4
`define KEY_NORMAL      5
`define KEY_PATH        6
`define KEY_SPAN_LOW    7
`define KEY_SPAN_HIGH   8
`define KEY_DETAIL      9
`define KEY_COUNT       10

// Last index of each bank
`define LAST_USER       4'hE
`define LAST_SERVICE    4'hE
`define LAST_AUX        4'h9

// Reset values
`define RST_INDEX       4'h0
`define RST_PATH_A      1'b1

// Timing
`define CLK_HZ          64'd50000000
`define HOLD_DELAY_MS   64'd1000
`define REPEAT_MS       64'd250
`define IDLE_TIMEOUT_S  64'd600

`endif

//--- src/keypad_nav_pkg.sv
package keypad_nav_pkg;

	typedef enum logic [1:0] {
		BANK_USER    = 2'b00,
		BANK_SERVICE = 2'b01,
		BANK_AUX     = 2'b10
	} bank_t;

	typedef enum logic [1:0] {
		DETAIL_NONE     = 2'b00,
		DETAIL_EXPONENT = 2'b01,
		DETAIL_EXTENDED = 2'b10
	} detail_t;

	// Request for a value to show, sent to the host
	typedef struct packed {
		bank_t       bank;
		logic [3:0]  index;
		logic        path_b;
		detail_t     detail;
	} value_req_t;

	// What the six digits show
	typedef struct packed {
		bank_t       bank;
		logic [3:0]  index;
		logic [15:0] value;
	} display_t;

	typedef struct packed {
		logic fault;
		logic in_cal;
		logic path_a;
		logic power;
	} lamps_t;

	// One-cycle mode commands to the instrument
	typedef struct packed {
		logic zero_cal;
		logic span_low_cal;
		logic cal_cycle;
		logic normal_mode;
	} mode_cmd_t;

endpackage : keypad_nav_pkg

//--- src/hold_repeat.sv
`timescale 1ns/1ps
module hold_repeat #(
	parameter bit          FIRST_NOW = 1'b1,
	parameter logic [31:0] HOLD_CYC  = 32'd50000000,
	parameter logic [31:0] REP_CYC   = 32'd12500000
) (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Combination state
	input  wire logic active_i,
	output logic      step_o
);

	logic        active_q;
	logic        rep_q;
	logic [31:0] cnt_q;
	logic [31:0] since_q;
	logic        rise;
	logic        reached;

	assign rise    = active_i & ~active_q;
	assign reached = rep_q ? (cnt_q == REP_CYC - 32'd1)
	                       : (cnt_q == HOLD_CYC - 32'd1);
	// First step on the press or only after the hold delay
	assign step_o  = (rise & FIRST_NOW) | (active_i & active_q & reached);

	// Edge memory
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			active_q <= 1'b0;
		else
			active_q <= active_i;
	end

	// Hold delay, then repeat interval while held
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !active_i || rise) begin
			cnt_q <= 32'h0;
			rep_q <= 1'b0;
		end else if (reached) begin
			cnt_q <= 32'h0;
			rep_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'd1;
		end
	end

	// Cycles since the combination was made, saturating
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || rise)
			since_q <= 32'h0;
		else if (since_q != 32'hFFFFFFFF)
			since_q <= since_q + 32'd1;
	end

	property p_no_early_step;
		@(posedge ref_clk_i) disable iff (rst_i)
		(step_o && !(rise && FIRST_NOW)) |-> since_q >= HOLD_CYC - 32'd1;
	endproperty
	a_no_early_step: assert property (p_no_early_step)
		else $error("hold step came before the hold delay");

	property p_repeat_gap;
		@(posedge ref_clk_i) disable iff (rst_i)
		(step_o && rep_q) |-> cnt_q == REP_CYC - 32'd1;
	endproperty
	a_repeat_gap: assert property (p_repeat_gap)
		else $error("repeat step off its interval");

	c_repeat: cover property (@(posedge ref_clk_i) step_o && rep_q);

endmodule : hold_repeat

//--- src/keypad_display_nav.sv
`timescale 1ns/1ps
`include "keypad_nav_map.svh"
module keypad_display_nav #(
	parameter logic [31:0] HOLD_CYCLES =
		32'(`HOLD_DELAY_MS * (`CLK_HZ / 64'd1000)),
	parameter logic [31:0] REPEAT_CYCLES =
		32'(`REPEAT_MS * (`CLK_HZ / 64'd1000)),
	parameter logic [35:0] IDLE_CYCLES =
		36'(`IDLE_TIMEOUT_S * `CLK_HZ)
) (
	// Clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_i,
	// Keypad pins, high while pressed
	input  wire logic [`KEY_COUNT-1:0]     keys_i,
	// Host status and value, same clock
	input  wire logic                      fault_i,
	input  wire logic                      in_cal_i,
	input  wire logic [15:0]               value_i,
	// Display, lamps, requests and commands
	output keypad_nav_pkg::display_t       display_o,
	output keypad_nav_pkg::lamps_t         lamps_o,
	output keypad_nav_pkg::value_req_t     req_o,
	output keypad_nav_pkg::mode_cmd_t      cmd_o
);

	localparam logic [`KEY_COUNT-1:0] ONE = 10'h001;

	logic [`KEY_COUNT-1:0]      sync1_q;
	logic [`KEY_COUNT-1:0]      keys_q;
	logic [`KEY_COUNT-1:0]      prev_q;
	logic [`KEY_COUNT-1:0]      press;
	logic                       any_press;
	keypad_nav_pkg::bank_t      bank_q;
	logic [3:0]                 index_q;
	logic                       path_a_q;
	logic [35:0]                idle_q;
	logic                       idle_done;
	logic                       adv_step;
	logic                       inc_step;
	logic                       dec_step;
	logic                       combo_cycle;
	logic                       combo_cycle_q;
	keypad_nav_pkg::display_t   display_q;
	keypad_nav_pkg::lamps_t     lamps_q;
	keypad_nav_pkg::value_req_t req_q;
	keypad_nav_pkg::mode_cmd_t  cmd_q;
	keypad_nav_pkg::detail_t    detail_d;
	logic [3:0]                 last_idx;

	function automatic logic alone(input logic [`KEY_COUNT-1:0] k,
	                               input int pos);
		alone = (k == (ONE << pos));
	endfunction : alone

	function automatic logic pair(input logic [`KEY_COUNT-1:0] k,
	                              input int a, input int b);
		pair = (k == ((ONE << a) | (ONE << b)));
	endfunction : pair

	// Two-stage synchroniser; pins are asynchronous to the clock
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sync1_q <= 10'h000;
			keys_q  <= 10'h000;
			prev_q  <= 10'h000;
		end else begin
			sync1_q <= keys_i;
			keys_q  <= sync1_q;
			prev_q  <= keys_q;
		end
	end

	assign press     = keys_q & ~prev_q;
	assign any_press = |press;

	// Repeating pair actions; index steps act at once, bank needs the hold
	hold_repeat #(
		.FIRST_NOW (1'b0),
		.HOLD_CYC  (HOLD_CYCLES),
		.REP_CYC   (REPEAT_CYCLES)
	) u_bank_rep (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.active_i  (pair(keys_q, `KEY_DISPLAY, `KEY_LEFT)),
		.step_o    (adv_step)
	);

	hold_repeat #(
		.FIRST_NOW (1'b1),
		.HOLD_CYC  (HOLD_CYCLES),
		.REP_CYC   (REPEAT_CYCLES)
	) u_inc_rep (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.active_i  (pair(keys_q, `KEY_DISPLAY, `KEY_INC)),
		.step_o    (inc_step)
	);

	hold_repeat #(
		.FIRST_NOW (1'b1),
		.HOLD_CYC  (HOLD_CYCLES),
		.REP_CYC   (REPEAT_CYCLES)
	) u_dec_rep (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.active_i  (pair(keys_q, `KEY_DISPLAY, `KEY_STEP_DOWN)),
		.step_o    (dec_step)
	);

	// Inactivity timer, restarted by any new press
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || any_press || idle_done)
			idle_q <= 36'h0;
		else
			idle_q <= idle_q + 36'd1;
	end

	assign idle_done = (idle_q == IDLE_CYCLES - 36'd1);

	// Last entry of the selected bank
	always_comb begin
		unique case (bank_q)
			keypad_nav_pkg::BANK_USER:    last_idx = `LAST_USER;
			keypad_nav_pkg::BANK_SERVICE: last_idx = `LAST_SERVICE;
			keypad_nav_pkg::BANK_AUX:     last_idx = `LAST_AUX;
			default:                      last_idx = `LAST_AUX;
		endcase
	end

	// Bank selection; a bank advance restarts at entry 0, idle return keeps the index
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bank_q <= keypad_nav_pkg::BANK_USER;
		end else if (adv_step) begin
			unique case (bank_q)
				keypad_nav_pkg::BANK_USER:
					bank_q <= keypad_nav_pkg::BANK_SERVICE;
				keypad_nav_pkg::BANK_SERVICE:
					bank_q <= keypad_nav_pkg::BANK_AUX;
				default:
					bank_q <= keypad_nav_pkg::BANK_USER;
			endcase
		end else if (idle_done) begin
			bank_q <= keypad_nav_pkg::BANK_USER;
		end
	end

	// Parameter index with wrap at both ends
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || adv_step)
			index_q <= `RST_INDEX;
		else if (inc_step)
			index_q <= (index_q >= last_idx) ? 4'h0 : index_q + 4'h1;
		else if (dec_step)
			index_q <= (index_q == 4'h0) ? last_idx : index_q - 4'h1;
	end

	// Path toggle on a lone path press
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			path_a_q <= `RST_PATH_A;
		else if (press[`KEY_PATH] && alone(keys_q, `KEY_PATH))
			path_a_q <= ~path_a_q;
	end

	// Detail class of the current entry while the detail key is held
	always_comb begin
		detail_d = keypad_nav_pkg::DETAIL_NONE;
		if (alone(keys_q, `KEY_DETAIL)) begin
			unique case (bank_q)
				keypad_nav_pkg::BANK_USER: begin
					if (index_q >= 4'hD)
						detail_d = keypad_nav_pkg::DETAIL_EXTENDED;
					else if (index_q >= 4'h2 && index_q <= 4'hB)
						detail_d = keypad_nav_pkg::DETAIL_EXPONENT;
				end
				keypad_nav_pkg::BANK_SERVICE: begin
					if (index_q == 4'hE)
						detail_d = keypad_nav_pkg::DETAIL_EXPONENT;
					else if ((index_q >= 4'h2 && index_q <= 4'h5) ||
					         (index_q >= 4'hA && index_q <= 4'hD))
						detail_d = keypad_nav_pkg::DETAIL_EXTENDED;
				end
				default: begin
					if (index_q == 4'h4 || index_q == 4'h5)
						detail_d = keypad_nav_pkg::DETAIL_EXTENDED;
					else if (index_q == 4'h6 || index_q == 4'h7)
						detail_d = keypad_nav_pkg::DETAIL_EXPONENT;
				end
			endcase
		end
	end

	// Span plus zero: fires once when the pair is complete
	assign combo_cycle = pair(keys_q, `KEY_SPAN_HIGH, `KEY_ZERO) ||
	                     pair(keys_q, `KEY_SPAN_LOW, `KEY_ZERO);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			combo_cycle_q <= 1'b0;
		else
			combo_cycle_q <= combo_cycle;
	end

	// Mode command pulses; the block has no path to stored settings
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cmd_q <= '0;
		end else begin
			cmd_q.zero_cal     <= press[`KEY_ZERO] &&
			                      alone(keys_q, `KEY_ZERO);
			cmd_q.normal_mode  <= press[`KEY_NORMAL] &&
			                      alone(keys_q, `KEY_NORMAL);
			cmd_q.span_low_cal <= press[`KEY_SPAN_LOW] &&
			                      alone(keys_q, `KEY_SPAN_LOW);
			cmd_q.cal_cycle    <= combo_cycle && !combo_cycle_q;
		end
	end

	// Display, request and lamps registered from current state
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			display_q <= '0;
			req_q     <= '0;
			lamps_q   <= '0;
		end else begin
			display_q.bank  <= bank_q;
			display_q.index <= index_q;
			display_q.value <= value_i;
			req_q.bank      <= bank_q;
			req_q.index     <= index_q;
			req_q.path_b    <= ~path_a_q;
			req_q.detail    <= detail_d;
			lamps_q.fault   <= fault_i;
			lamps_q.in_cal  <= in_cal_i;
			lamps_q.path_a  <= path_a_q;
			lamps_q.power   <= 1'b1;
		end
	end

	assign display_o = display_q;
	assign req_o     = req_q;
	assign lamps_o   = lamps_q;
	assign cmd_o     = cmd_q;

	property p_zero_alone;
		@(posedge ref_clk_i) disable iff (rst_i)
		(press[`KEY_ZERO] && alone(keys_q, `KEY_ZERO)) |=>
			cmd_o.zero_cal && !cmd_o.cal_cycle;
	endproperty
	a_zero_alone: assert property (p_zero_alone)
		else $error("zero press gave no zero request");

	property p_normal;
		@(posedge ref_clk_i) disable iff (rst_i)
		(press[`KEY_NORMAL] && alone(keys_q, `KEY_NORMAL)) |=>
			cmd_o.normal_mode;
	endproperty
	a_normal: assert property (p_normal)
		else $error("normal press gave no mode command");

	property p_span_low;
		@(posedge ref_clk_i) disable iff (rst_i)
		(press[`KEY_SPAN_LOW] && alone(keys_q, `KEY_SPAN_LOW)) |=>
			cmd_o.span_low_cal;
	endproperty
	a_span_low: assert property (p_span_low)
		else $error("span-low press gave no request");

	property p_cycle;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(combo_cycle) |=> cmd_o.cal_cycle && !cmd_o.zero_cal
			##1 !cmd_o.cal_cycle;
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("calibration cycle pulse wrong");

	property p_path_lamp;
		@(posedge ref_clk_i) disable iff (rst_i)
		(press[`KEY_PATH] && alone(keys_q, `KEY_PATH)) |=>
			##1 (lamps_o.path_a != $past(lamps_o.path_a)) &&
			(req_o.path_b == !lamps_o.path_a);
	endproperty
	a_path_lamp: assert property (p_path_lamp)
		else $error("path lamp did not follow the path");

	property p_inc_wrap;
		@(posedge ref_clk_i) disable iff (rst_i)
		(inc_step && !adv_step && index_q == last_idx) |=> index_q == 4'h0;
	endproperty
	a_inc_wrap: assert property (p_inc_wrap)
		else $error("increment did not wrap to zero");

	property p_dec_wrap;
		@(posedge ref_clk_i) disable iff (rst_i)
		(dec_step && !inc_step && !adv_step && index_q == 4'h0) |=>
			index_q == $past(last_idx);
	endproperty
	a_dec_wrap: assert property (p_dec_wrap)
		else $error("step down did not wrap to last entry");

	property p_idle_user;
		@(posedge ref_clk_i) disable iff (rst_i)
		(idle_done && !adv_step) |=> bank_q == keypad_nav_pkg::BANK_USER
			##1 display_o.bank == keypad_nav_pkg::BANK_USER;
	endproperty
	a_idle_user: assert property (p_idle_user)
		else $error("idle timeout did not return to user bank");

	property p_bank_order;
		@(posedge ref_clk_i) disable iff (rst_i)
		(adv_step && bank_q == keypad_nav_pkg::BANK_USER) |=>
			bank_q == keypad_nav_pkg::BANK_SERVICE && index_q == 4'h0;
	endproperty
	a_bank_order: assert property (p_bank_order)
		else $error("bank did not advance user to service");

	property p_power;
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |=> lamps_o.power [*3];
	endproperty
	a_power: assert property (p_power)
		else $error("power lamp not lit");

	c_zero:  cover property (@(posedge ref_clk_i) cmd_o.zero_cal);
	c_cycle: cover property (@(posedge ref_clk_i) cmd_o.cal_cycle);
	c_aux:   cover property (@(posedge ref_clk_i)
		bank_q == keypad_nav_pkg::BANK_AUX && inc_step);
	c_ext:   cover property (@(posedge ref_clk_i)
		req_o.detail == keypad_nav_pkg::DETAIL_EXTENDED);

endmodule : keypad_display_nav

//--- dv/keypad_operator.sv
`timescale 1ns/1ps
module keypad_operator (
	// Clock
	input  wire logic                     ref_clk_i,
	// Keypad pins, high while pressed
	output logic [9:0]                    keys_o,
	// What the navigator shows
	input  wire keypad_nav_pkg::display_t display_i,
	input  wire keypad_nav_pkg::lamps_t   lamps_i
);
	keypad_nav_pkg::display_t shown_q;
	keypad_nav_pkg::lamps_t   lit_q;

	// Operator starts with hands off the keypad
	initial keys_o = 10'h000;

	// What the operator last read off the digits and lamps
	always @(posedge ref_clk_i) begin
		shown_q <= display_i;
		lit_q <= lamps_i;
	end

	// Pins move just after an edge so the synchroniser never races them
	task automatic hold_keys(input logic [9:0] mask);
		@(posedge ref_clk_i);
		#2 keys_o = mask;
	endtask : hold_keys

	// Short or long press; length chooses prompt or slow operator
	task automatic press(input logic [9:0] mask, input int cyc);
		hold_keys(mask);
		repeat (cyc) @(posedge ref_clk_i);
		#2 keys_o = 10'h000;
	endtask : press
endmodule : keypad_operator

//--- dv/local_keypad_display_navigator_test.sv
`timescale 1ns/1ps
`include "keypad_nav_map.svh"
module local_keypad_display_navigator_test;
	// Short counts keep the run brief
	localparam int HOLD = 20;
	localparam int REP  = 5;
	localparam int IDLE = 200;
	localparam logic [9:0] DSP = 10'h001 << `KEY_DISPLAY;
	localparam logic [9:0] LFT = 10'h001 << `KEY_LEFT;
	localparam logic [9:0] INC = 10'h001 << `KEY_INC;
	localparam logic [9:0] DWN = 10'h001 << `KEY_STEP_DOWN;
	localparam logic [9:0] ZRO = 10'h001 << `KEY_ZERO;
	localparam logic [9:0] NRM = 10'h001 << `KEY_NORMAL;
	localparam logic [9:0] PTH = 10'h001 << `KEY_PATH;
	localparam logic [9:0] SLO = 10'h001 << `KEY_SPAN_LOW;
	localparam logic [9:0] SHI = 10'h001 << `KEY_SPAN_HIGH;
	localparam logic [9:0] DTL = 10'h001 << `KEY_DETAIL;

	// Row: pins, pulses expected (zero, span low, cycle, normal), index after
	typedef struct packed {
		logic [9:0] k;
		logic [3:0] cmd;
		logic [3:0] idx;
	} row_t;

	logic                       ref_clk_i;
	logic                       rst_i;
	logic                       fault_i;
	logic                       in_cal_i;
	logic [15:0]                value_i;
	logic [9:0]                 keys;
	keypad_nav_pkg::display_t   display_o;
	keypad_nav_pkg::lamps_t     lamps_o;
	keypad_nav_pkg::value_req_t req_o;
	keypad_nav_pkg::mode_cmd_t  cmd_o;
	row_t                       rows [10];
	int                         err_count;
	int                         checks;
	int                         cycles;
	int                         tally [4];
	int                         snap [4];
	int                         n;

	keypad_display_nav #(
		.HOLD_CYCLES(32'(HOLD)),
		.REPEAT_CYCLES(32'(REP)),
		.IDLE_CYCLES(36'(IDLE))
	) dut_u (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.keys_i(keys),
		.fault_i(fault_i),
		.in_cal_i(in_cal_i),
		.value_i(value_i),
		.display_o(display_o),
		.lamps_o(lamps_o),
		.req_o(req_o),
		.cmd_o(cmd_o)
	);

	keypad_operator op_u (
		.ref_clk_i(ref_clk_i),
		.keys_o(keys),
		.display_i(display_o),
		.lamps_i(lamps_o)
	);

	// Clock
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// Pulse tallies and the hang guard
	always @(posedge ref_clk_i) begin
		cycles++;
		for (int i = 0; i < 4; i++) begin
			tally[i] += int'(cmd_o[i] === 1'b1);
		end
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Settled bank and index are looked at 1 ns after each edge
	task automatic wait_change(output int cnt);
		logic [5:0] old;
		old = {display_o.bank, display_o.index};
		cnt = 0;
		while ({display_o.bank, display_o.index} === old && cnt < 1000) begin
			@(posedge ref_clk_i);
			#1 cnt++;
		end
	endtask : wait_change

	function automatic logic [1:0] exp_det(input int b, input int i);
		case (b)
			0: return (i < 2 || i == 12) ? keypad_nav_pkg::DETAIL_NONE :
				(i > 12) ? keypad_nav_pkg::DETAIL_EXTENDED :
				keypad_nav_pkg::DETAIL_EXPONENT;
			1: return (i == 14) ? keypad_nav_pkg::DETAIL_EXPONENT :
				((i >= 2 && i <= 5) || (i >= 10 && i <= 13)) ?
				keypad_nav_pkg::DETAIL_EXTENDED : keypad_nav_pkg::DETAIL_NONE;
			default: return (i == 4 || i == 5) ?
				keypad_nav_pkg::DETAIL_EXTENDED : (i == 6 || i == 7) ?
				keypad_nav_pkg::DETAIL_EXPONENT : keypad_nav_pkg::DETAIL_NONE;
		endcase
	endfunction : exp_det

	task automatic test_done();
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		rst_i = 1'b1;
		fault_i = 1'b0;
		in_cal_i = 1'b0;
		value_i = 16'hA5C3;
		rows = '{'{ZRO, 4'h8, 4'h0}, '{NRM, 4'h1, 4'h0}, '{SLO, 4'h4, 4'h0},
			'{SHI | ZRO, 4'h2, 4'h0}, '{SLO | ZRO, 4'h2, 4'h0},
			'{SHI, 4'h0, 4'h0}, '{DSP | INC, 4'h0, 4'h1},
			'{DSP | DWN, 4'h0, 4'h0}, '{DSP | DWN, 4'h0, 4'hE},
			'{DSP | INC, 4'h0, 4'h0}};
		repeat (5) @(posedge ref_clk_i);
		#2 rst_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1 chk({display_o.bank, display_o.index}, 32'h0);
		chk({lamps_o.path_a, lamps_o.power, cmd_o}, 32'h30);
		chk(display_o.value, 32'hA5C3);
		chk(op_u.shown_q.value, 32'hA5C3);
		// Lone keys, pairs and ignored keys, one row each
		foreach (rows[r]) begin
			snap = tally;
			op_u.press(rows[r].k, 3);
			repeat (8) @(posedge ref_clk_i);
			#1 for (int i = 0; i < 4; i++) begin
				chk(tally[i] - snap[i], rows[r].cmd[i]);
			end
			chk(display_o.index, rows[r].idx);
		end
		// Every entry of every bank with the detail key, then bank advance
		for (int b = 0; b < 3; b++) begin
			for (int i = 0; i <= ((b == 2) ? 9 : 14); i++) begin
				op_u.press(DTL, 5);
				chk(req_o.detail, exp_det(b, i));
				chk({display_o.bank, display_o.index}, {b[1:0], i[3:0]});
				chk({req_o.bank, req_o.index}, {b[1:0], i[3:0]});
				op_u.press(DSP | INC, 2);
				repeat (4) @(posedge ref_clk_i);
			end
			chk(display_o.index, 32'h0);
			op_u.press(DSP | LFT, HOLD + 2);
			repeat (4) @(posedge ref_clk_i);
			#1 chk(display_o.bank, (b + 1) % 3);
		end
		// Held increment: first step at once, then hold delay, then repeat
		op_u.hold_keys(DSP | INC);
		wait_change(n);
		wait_change(n);
		chk(n >= HOLD - 1 && n <= HOLD + 1, 1);
		wait_change(n);
		chk(n >= REP - 1 && n <= REP + 1, 1);
		op_u.hold_keys(10'h000);
		// Held bank pair advances twice, and the bank is still auxiliary 150 idle cycles later
		op_u.hold_keys(DSP | LFT);
		wait_change(n);
		chk(n >= HOLD && n <= HOLD + 5, 1);
		wait_change(n);
		chk(n >= REP - 1 && n <= REP + 1, 1);
		op_u.hold_keys(10'h000);
		repeat (150) @(posedge ref_clk_i);
		#1 chk(display_o.bank, keypad_nav_pkg::BANK_AUX);
		// A key with no action of its own still restarts the idle count
		op_u.press(SHI, 2);
		repeat (150) @(posedge ref_clk_i);
		#1 chk(display_o.bank, keypad_nav_pkg::BANK_AUX);
		wait_change(n);
		chk(display_o.bank, keypad_nav_pkg::BANK_USER);
		chk(n >= 50 && n <= 54, 1);
		// Path toggles both ways and the lamp follows
		op_u.press(PTH, 3);
		repeat (6) @(posedge ref_clk_i);
		#1 chk({lamps_o.path_a, req_o.path_b}, 32'h1);
		op_u.press(PTH, 3);
		repeat (6) @(posedge ref_clk_i);
		#1 chk({lamps_o.path_a, req_o.path_b}, 32'h2);
		// Host lamp states reach the lamps
		@(posedge ref_clk_i);
		#2 fault_i = 1'b1;
		in_cal_i = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 chk(lamps_o, 32'hF);
		chk(op_u.lit_q, 32'hF);
		// Path B and entry 1, then a reset in mid-run must clear both
		op_u.press(PTH, 3);
		op_u.press(DSP | INC, 3);
		repeat (6) @(posedge ref_clk_i);
		#1 chk({lamps_o, display_o.index}, 32'hD1);
		@(posedge ref_clk_i);
		#2 rst_i = 1'b1;
		repeat (5) @(posedge ref_clk_i);
		#1 chk(lamps_o, 32'h0);
		#1 rst_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1 chk({display_o.bank, display_o.index}, 32'h0);
		chk({lamps_o, cmd_o}, 32'hF0);
		test_done();
	end
endmodule : local_keypad_display_navigator_test
